/* File: verilog/i2c_slave_bus_front_end.sv */
`timescale 1ns/10ps
`include "i2c_slave_cfg.svh"
// Slave-only two-wire bus front end with strapped address.
module i2c_slave_bus_front_end (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Bus lines; the clock is input only, data is open drain.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps, three-state sensed outside.
  input wire i2c_slave_pkg::strap_t addr_strap_high,
  input wire i2c_slave_pkg::strap_t addr_strap_low,
  // Byte stream towards the register side.
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic tx_req,
  // Bus status.
  output logic bus_busy,
  output logic addressed,
  output logic read_mode,
  output logic start_seen,
  output logic stop_seen
);
  import i2c_slave_pkg::*;

  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  seq_t st_q;
  logic [2:0] bit_q;
  logic skip_q; // Set by a start; swallows the clock fall that closes the start.
  logic [7:0] sh_q;
  logic [7:0] txsh_q;
  logic [`BUS_FREE_W-1:0] free_q;
  logic [6:0] own_addr;

  // Map the two strap levels to the bus address.
  function automatic logic [6:0] strap_addr(input strap_t hi, input strap_t lo);
    if (hi != strap_float && lo != strap_float) begin
      strap_addr = `ADDR_BASE | {5'h00, hi[0], lo[0]};
    end else if (hi == strap_low && lo == strap_float) begin
      strap_addr = `ADDR_FLOAT_LF;
    end else if (hi == strap_float && lo == strap_low) begin
      strap_addr = `ADDR_FLOAT_FL;
    end else if (hi == strap_high && lo == strap_float) begin
      strap_addr = `ADDR_FLOAT_HF;
    end else if (hi == strap_float && lo == strap_high) begin
      strap_addr = `ADDR_FLOAT_FH;
    end else begin
      strap_addr = `ADDR_FLOAT_FF;
    end
  endfunction : strap_addr

  // Clean both lines; the bus clock is sampled, never driven.
  pin_sync u_scl (.clk(clk), .rst(rst), .pin(scl_in), .level(scl_s));
  pin_sync u_sda (.clk(clk), .rst(rst), .pin(sda_in), .level(sda_s));

  // Edge and condition detection from the cleaned lines.
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Address is fixed by straps, no programmable setting.
  always_ff @(posedge clk) begin
    if (rst) begin
      own_addr <= 7'h00;
    end else begin
      own_addr <= strap_addr(addr_strap_high, addr_strap_low);
    end
  end

  // Previous line levels for edge finding.
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Condition pulses for the register side.
  always_ff @(posedge clk) begin
    if (rst) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      start_seen <= start_ev;
      stop_seen <= stop_ev;
    end
  end

  // Busy from start, kept over repeated start, free after bus free time.
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_busy <= 1'b0;
      free_q <= '0;
    end else if (start_ev) begin
      bus_busy <= 1'b1;
      free_q <= '0;
    end else if (stop_ev) begin
      free_q <= `BUS_FREE_W'(`BUS_FREE_CYC);
    end else if (free_q != '0) begin
      free_q <= free_q - 1'b1;
      if (free_q == `BUS_FREE_W'(1)) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // Protocol sequencer; advances on bus clock edges and start/stop conditions only, so any rate works.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= st_idle;
      bit_q <= 3'h0;
      skip_q <= 1'b0;
      sh_q <= 8'h00;
      addressed <= 1'b0;
      read_mode <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      tx_req <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_req <= 1'b0;
      if (start_ev) begin
        st_q <= st_addr;
        bit_q <= 3'h0;
        skip_q <= 1'b1;
        addressed <= 1'b0;
      end else if (stop_ev) begin
        st_q <= st_idle;
        skip_q <= 1'b0;
        addressed <= 1'b0;
      end else begin
        case (st_q)
          st_addr, st_data: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
            end
            // The clock fall that ends a start carries no bit, so it is not counted.
            if (scl_fall && skip_q) begin
              skip_q <= 1'b0;
            end else if (scl_fall) begin
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                if (st_q == st_addr) begin
                  if (sh_q[7:1] == own_addr) begin
                    addressed <= 1'b1;
                    read_mode <= sh_q[0];
                    st_q <= st_ack;
                  end else begin
                    st_q <= st_idle;
                  end
                end else if (read_mode) begin
                  st_q <= st_mack;
                end else begin
                  rx_byte <= sh_q;
                  rx_valid <= 1'b1;
                  st_q <= st_ack;
                end
              end
            end
          end
          st_ack: begin
            if (scl_fall) begin
              st_q <= st_data;
              bit_q <= 3'h0;
              tx_req <= read_mode;
            end
          end
          st_mack: begin
            if (scl_rise) begin
              sh_q[0] <= sda_s;
            end
            if (scl_fall) begin
              bit_q <= 3'h0;
              if (sh_q[0]) begin
                st_q <= st_idle;
              end else begin
                st_q <= st_data;
                tx_req <= 1'b1;
              end
            end
          end
          default: begin
            st_q <= st_idle;
          end
        endcase
      end
    end
  end

  // Transmit shift register; loads at the end of each acknowledge slot.
  always_ff @(posedge clk) begin
    if (rst) begin
      txsh_q <= 8'hff;
    end else if (scl_fall && (st_q == st_ack || st_q == st_mack)) begin
      txsh_q <= tx_byte;
    end else if (scl_fall && st_q == st_data && read_mode) begin
      txsh_q <= {txsh_q[6:0], 1'b1};
    end
  end

  // Data line drive; changed only while the bus clock is low.
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (st_q == st_addr && bit_q == 3'h7 && sh_q[7:1] == own_addr) begin
        sda_oe <= 1'b1;
      end else if (st_q == st_data && bit_q == 3'h7 && !read_mode) begin
        sda_oe <= 1'b1;
      end else if (st_q == st_ack && read_mode) begin
        sda_oe <= ~tx_byte[7];
      end else if (st_q == st_mack && !sh_q[0]) begin
        sda_oe <= ~tx_byte[7];
      end else if (st_q == st_data && read_mode && bit_q != 3'h7) begin
        sda_oe <= ~txsh_q[6];
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end
endmodule : i2c_slave_bus_front_end

/* File: verilog/i2c_slave_cfg.svh */
// Summary of operation
// - Slave only; never drives or stretches clock.
// - Handles any bus rate up to 400 kbit/s.
// - One bit per clock pulse, stable while high.
// - Data fall with clock high is start.
// - Data rise with clock high is stop.
// - Busy from start until after stop.
// - Single seven-bit address fixed by straps.
// - Logic straps give 1010000 through 1010011.
// - Floating straps give 1010100 through 1011000.
// - Each byte followed by acknowledge; unlimited bytes.
// - Transmitter releases data; acknowledger holds low.
// - Addressed receiving device acknowledges every byte.
// - After master nack, device releases data line.
// - First seven bits after start compared with address.
// - Eighth address bit gives transfer direction.
`ifndef I2C_SLAVE_CFG_SVH
`define I2C_SLAVE_CFG_SVH
`define ADDR_BASE 7'h50
`define ADDR_FLOAT_LF 7'h54
`define ADDR_FLOAT_FL 7'h55
`define ADDR_FLOAT_HF 7'h56
`define ADDR_FLOAT_FH 7'h57
`define ADDR_FLOAT_FF 7'h58
`define CLK_PERIOD_NS 4
`define BUS_FREE_NS 1300
`define BUS_FREE_CYC ((`BUS_FREE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_FREE_W 9
`endif

/* File: verilog/i2c_slave_pkg.sv */
package i2c_slave_pkg;
  // Strap level as seen by the strap sensing logic.
  typedef enum logic [1:0] {
    strap_low = 2'h0,
    strap_high = 2'h1,
    strap_float = 2'h2
  } strap_t;
  // Protocol sequencer states.
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_addr = 5'h02,
    st_ack = 5'h04,
    st_data = 5'h08,
    st_mack = 5'h10
  } seq_t;
endpackage : i2c_slave_pkg

/* File: verilog/pin_sync.sv */
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree.
module pin_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous pin and clean level.
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Shift the pin through the three stages.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Accept a new level only when the last two stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b1;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule : pin_sync

/* File: dv/i2c_slave_bus_front_end_properties.sv */
`timescale 1ns/10ps
// Port checker for the bus front end.
module i2c_slave_bus_front_end_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Bus and straps.
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire i2c_slave_pkg::strap_t addr_strap_high,
  input wire i2c_slave_pkg::strap_t addr_strap_low,
  // Bytes and status.
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic tx_req,
  input wire logic bus_busy,
  input wire logic addressed,
  input wire logic read_mode,
  input wire logic start_seen,
  input wire logic stop_seen
);
  import i2c_slave_pkg::*;
  logic [9:0] gap_q; // Clocks since the last stop.
  // Counts up from each stop and saturates.
  always_ff @(posedge clk) begin
    if (rst || stop_seen)
      gap_q <= 10'h0;
    else if (gap_q != 10'h3ff)
      gap_q <= gap_q + 10'h1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_open_drain: assert property (sda_out == 1'b0)
    else $error("data driven high");
  chk_edge_clk_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved with clock high");
  chk_ack_hold: assert property ($rose(sda_oe) |-> sda_oe[*8])
    else $error("drive too short");
  chk_start_busy: assert property (start_seen |-> ##[0:2] bus_busy)
    else $error("busy not set");
  chk_start_quiet: assert property (start_seen |-> !sda_oe)
    else $error("driving at start");
  chk_stop_clear: assert property (stop_seen |-> ##[0:2] !addressed)
    else $error("still addressed");
  chk_free_time: assert property ($fell(bus_busy) |-> gap_q inside {[10'h13e:10'h14c]})
    else $error("bus free too early or late");
  chk_write_ack: assert property (rx_valid && addressed && !read_mode |-> ##[0:4] sda_oe)
    else $error("byte not acknowledged");
  chk_match_drive: assert property ($rose(sda_oe) |-> ##[0:2] addressed)
    else $error("drive without match");
  chk_tx_dir: assert property (tx_req |-> addressed && read_mode)
    else $error("send request outside read");
  cover property (tx_req);
  cover property (rx_valid && addressed);
  cover property ($fell(bus_busy));
endmodule : i2c_slave_bus_front_end_properties
bind i2c_slave_bus_front_end i2c_slave_bus_front_end_properties
  i2c_slave_bus_front_end_properties_inst (.clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe,
  .addr_strap_high, .addr_strap_low, .tx_byte, .rx_byte, .rx_valid, .tx_req, .bus_busy,
  .addressed, .read_mode, .start_seen, .stop_seen);

/* File: dv/i2c_master_model.sv */
`timescale 1ns/10ps
// Bus master; a quarter bit is five clocks.
module i2c_master_model (
  // Clock and wired data level.
  input wire logic clk,
  input wire logic sda,
  // Driven clock and open-drain data (1 releases).
  output logic scl,
  output logic sda_m
);
  localparam int Q = 5; // Clocks per quarter bit.
  // Both lines idle high.
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Waits n falling clock edges.
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  // Start, after the free time when idle, else repeated.
  task automatic start(input logic idle);
    if (idle)
      w(340);
    sda_m = 1'b1;
    w(Q);
    scl = 1'b1;
    w(Q);
    sda_m = 1'b0;
    w(Q);
    scl = 1'b0;
    w(Q);
  endtask : start
  // One bit; data moves only with the clock low.
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    w(Q);
    scl = 1'b1;
    w(Q);
    r = sda;
    w(Q);
    scl = 1'b0;
    w(Q);
  endtask : bitx
  // Eight bits then the acknowledge slot; a is the master's own acknowledge.
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ak);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(a, ak);
  endtask : xfer
  // Stop condition.
  task automatic stop;
    sda_m = 1'b0;
    w(Q);
    scl = 1'b1;
    w(Q);
    sda_m = 1'b1;
    w(2 * Q);
  endtask : stop
endmodule : i2c_master_model

/* File: dv/i2c_slave_bus_front_end_bench.sv */
`timescale 1ns/10ps
// Drives the front end through the master model.
module i2c_slave_bus_front_end_bench;
  import i2c_slave_pkg::*;
  logic clk, rst, scl_in, sda_in, sda_m, sda_out, sda_oe, rx_valid, tx_req;
  logic bus_busy, addressed, read_mode, start_seen, stop_seen;
  logic [7:0] tx_byte, rx_byte;
  strap_t addr_strap_high, addr_strap_low;
  int errors, checks, cyc;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
  // Data wire with pull-up.
  assign sda_in = sda_m & ~(sda_oe & ~sda_out);
  i2c_slave_bus_front_end i2c_slave_bus_front_end_inst (.clk, .rst, .scl_in, .sda_in,
    .sda_out, .sda_oe, .addr_strap_high, .addr_strap_low, .tx_byte, .rx_byte, .rx_valid,
    .tx_req, .bus_busy, .addressed, .read_mode, .start_seen, .stop_seen);
  i2c_master_model i2c_master_model_inst (.clk, .sda(sda_in), .scl(scl_in), .sda_m);
  // Clock of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Ends a hung run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // Sends one byte and compares the acknowledge level.
  task automatic wr(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic ak;
    i2c_master_model_inst.xfer(d, 1'b1, q, ak);
    `CHK("ack", e, ak)
  endtask : wr
  // Every strap pair: own address acknowledged, a neighbour ignored.
  task automatic t_straps;
    int h[9] = '{0, 0, 1, 1, 0, 2, 1, 2, 2};
    int l[9] = '{0, 1, 0, 1, 2, 0, 2, 1, 2};
    logic [6:0] a;
    for (int i = 0; i < 9; i++) begin
      addr_strap_high = strap_t'(h[i]);
      addr_strap_low = strap_t'(l[i]);
      for (int k = 0; k < 2; k++) begin
        a = 7'h50 + 7'(i) ^ (k ? 7'h08 : 7'h00);
        i2c_master_model_inst.start(1'b1);
        wr({a, 1'b0}, 1'(k));
        `CHK("addressed", 1'(!k), addressed)
        i2c_master_model_inst.stop();
      end
    end
  endtask : t_straps
  // Two data bytes, then the free time after stop.
  task automatic t_write;
    addr_strap_high = strap_high;
    addr_strap_low = strap_low;
    i2c_master_model_inst.start(1'b1);
    `CHK("busy", 1'b1, bus_busy)
    wr(8'ha4, 1'b0);
    `CHK("dir", 1'b0, read_mode)
    wr(8'h5a, 1'b0);
    `CHK("rx", 8'h5a, rx_byte)
    wr(8'h81, 1'b0);
    `CHK("rx", 8'h81, rx_byte)
    i2c_master_model_inst.stop();
    `CHK("addressed", 1'b0, addressed)
    repeat (300) @(negedge clk);
    `CHK("busy", 1'b1, bus_busy)
    repeat (40) @(negedge clk);
    `CHK("busy", 1'b0, bus_busy)
  endtask : t_write
  // Repeated starts: wrong address, then a two byte read ended by nack.
  task automatic t_read;
    logic [7:0] q;
    logic ak;
    tx_byte = 8'h96;
    i2c_master_model_inst.start(1'b1);
    wr(8'ha4, 1'b0);
    wr(8'h07, 1'b0);
    i2c_master_model_inst.start(1'b0);
    wr(8'ha7, 1'b1);
    i2c_master_model_inst.start(1'b0);
    `CHK("busy", 1'b1, bus_busy)
    wr(8'ha5, 1'b0);
    `CHK("dir", 1'b1, read_mode)
    fork
      i2c_master_model_inst.xfer(8'hff, 1'b0, q, ak);
      begin
        repeat (80) @(negedge clk);
        tx_byte = 8'h3c;
      end
    join
    `CHK("rd", 8'h96, q)
    i2c_master_model_inst.xfer(8'hff, 1'b1, q, ak);
    `CHK("rd", 8'h3c, q)
    `CHK("release", 1'b0, sda_oe)
    i2c_master_model_inst.stop();
    `CHK("addressed", 1'b0, addressed)
  endtask : t_read
  // Reset for six clocks, then the scenarios.
  initial begin
    errors = 0;
    checks = 0;
    cyc = 0;
    rst = 1'b1;
    tx_byte = 8'h00;
    addr_strap_high = strap_low;
    addr_strap_low = strap_low;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_straps();
    t_write();
    t_read();
    finish_test();
  end
endmodule : i2c_slave_bus_front_end_bench
